// >>> inc/fan_cfg_pkg.sv
package fan_cfg_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_SRC_MODE = 8'h96;
	localparam logic [7:0] IDX_HYS = 8'h98;
	localparam logic [7:0] IDX_RATE = 8'h9b;
	localparam logic [7:0] IDX_START_STOP = 8'h9c;
	localparam logic [7:0] IDX_PON = 8'h9e;
	localparam logic [7:0] IDX_BANK = 8'h9f;
	localparam logic [7:0] IDX_CNT_HI = 8'ha0;
	localparam logic [7:0] IDX_CNT_LO = 8'ha1;
	localparam logic [7:0] IDX_EXP_HI = 8'ha2;
	localparam logic [7:0] IDX_EXP_LO = 8'ha3;
	localparam logic [7:0] IDX_FULL_HI = 8'ha4;
	localparam logic [7:0] IDX_FULL_LO = 8'ha5;
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;
	// reset values
	localparam logic [2:0] RST_SRC = 3'h0;
	localparam logic [3:0] RST_MODE = 4'h5;
	localparam logic [7:0] RST_HYS = 8'h44;
	localparam logic [3:0] RST_RATE = 4'h5;
	localparam logic [7:0] RST_THR = 8'h55;
	localparam logic [7:0] RST_PON = 8'h66;
	localparam logic [15:0] RST_CNT = 16'h0fff;
	localparam logic [15:0] RST_EXP = 16'h0001;
	localparam logic [15:0] RST_FULL = 16'h03ff;
	// field positions
	localparam int BANK_BIT = 7;
	localparam int SLOW_BIT = 6;
	localparam int DIRECT_BIT = 6;
	localparam int START_SHIFT = 3;
	localparam int STOP_SHIFT = 2;
	localparam int SEG_FRAC_SHIFT = 5;
	localparam logic [7:0] DUTY_FULL = 8'hff;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		MODE_AUTO_RPM = 2'b00,
		MODE_AUTO_DUTY = 2'b01,
		MODE_MAN_RPM = 2'b10,
		MODE_MAN_DUTY = 2'b11
	} fan_mode_t;
	typedef enum logic [2:0] {
		SRC_EXT = 3'b000,
		SRC_ONE = 3'b001,
		SRC_TWO_A = 3'b010,
		SRC_TWO_B = 3'b011,
		SRC_CPU = 3'b100,
		SRC_PCH = 3'b101,
		SRC_MCH = 3'b110,
		SRC_MAX = 3'b111
	} src_sel_t;
	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int RATE_HZ_2 = 2;
	localparam int RATE_HZ_5 = 5;
	localparam int RATE_HZ_10 = 10;
	localparam int RATE_HZ_20 = 20;
	localparam int BASE_TICK_CYC = CLK_HZ / RATE_HZ_20;
	localparam int SUB_WRAP = RATE_HZ_20;
	localparam int RATE_DIV_2 = RATE_HZ_20 / RATE_HZ_2;
	localparam int RATE_DIV_5 = RATE_HZ_20 / RATE_HZ_5;
	localparam int RATE_DIV_10 = RATE_HZ_20 / RATE_HZ_10;
	localparam int PWM_HZ = 25_000;
	localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * 255);
	localparam int TACH_TICK_NS = 10_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int TACH_TICK_CYC = TACH_TICK_NS / CLK_PERIOD_NS;
	localparam int SLOW_FACTOR = 4;
	typedef struct packed {
		logic [7:0] ext;
		logic [7:0] one;
		logic [7:0] two;
		logic [7:0] cpu;
		logic [7:0] pch;
		logic [7:0] mch;
		logic [7:0] maxv;
	} temp_set_t;
	typedef struct packed {
		logic [7:0] boundary;
		logic [7:0] above;
		logic [7:0] below;
	} seg_cfg_t;
endpackage : fan_cfg_pkg

// >>> logic/fan_duty_control_config.sv
`timescale 1ns/1ps
// Notes on behaviour
// - three-bit selector picks fan one temperature
// - adjust_temp_source_select selector only with bank set
// - four-bit hysteresis per fan, reset four
// - segment up above boundary, down below minus hysteresis
// - bank zero 9Bh: up ramp rates
// - bank one 9Bh: down ramp rates
// - direct bit jumps duty to target
// - start jumps duty from zero to threshold times eight
// - slowing duty below threshold times four becomes zero
// - duty loaded from power-on register after reset
// - bit 7 of 9Fh selects bank
// - bit 6 of 9Fh selects slow tach monitor
// - reading count high latches count low
// - full-speed count uses same latching
// - expected high byte, hardware-updated in auto rpm mode only
// - expected low or duty, read-only in auto
// - duty N gives N/255 output
// - two-bit mode field per fan; only fan one's field steers its duty, fan two's is stored only
module fan_duty_control_config #(
	parameter int BASE_TICK_CYCLES = fan_cfg_pkg::BASE_TICK_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [fan_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fan_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// temperatures and segment settings
	input wire fan_cfg_pkg::temp_set_t temps,
	input wire logic [7:0] temp_fan_two,
	input wire fan_cfg_pkg::seg_cfg_t seg_one,
	input wire fan_cfg_pkg::seg_cfg_t seg_two,
	// fan side
	input wire logic tach_one,
	output logic drive_output_one,
	output logic drive_output_two,
	output logic [7:0] duty_one,
	output logic [7:0] duty_two
);
	import fan_cfg_pkg::*;

	// timers
	logic [23:0] base_r, base_nxt;
	logic [4:0] sub_r, sub_nxt;
	logic [7:0] pwm_pre_r, pwm_pre_nxt, pwm_cnt_r, pwm_cnt_nxt;
	logic base_tick, pwm_step;

	always_comb
	begin
		base_nxt = base_r + 24'h000001;
		sub_nxt = sub_r;
		base_tick = 1'b0;
		if (base_r == 24'(BASE_TICK_CYCLES - 1))
		begin
			base_nxt = '0;
			base_tick = 1'b1;
			sub_nxt = (sub_r == 5'(SUB_WRAP - 1)) ? 5'h00 : sub_r + 5'h01;
		end
		pwm_step = (pwm_pre_r == 8'(PWM_STEP_CYC - 1));
		pwm_pre_nxt = pwm_step ? 8'h00 : pwm_pre_r + 8'h01;
		pwm_cnt_nxt = pwm_cnt_r;
		if (pwm_step)
			pwm_cnt_nxt = (pwm_cnt_r == DUTY_FULL - 8'h01) ? 8'h00 : pwm_cnt_r + 8'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			base_r <= '0;
			sub_r <= '0;
			pwm_pre_r <= '0;
			pwm_cnt_r <= '0;
		end
		else
		begin
			base_r <= base_nxt;
			sub_r <= sub_nxt;
			pwm_pre_r <= pwm_pre_nxt;
			pwm_cnt_r <= pwm_cnt_nxt;
		end
	end

	// true on the base ticks that belong to the selected update rate
	function automatic logic rate_hit(input logic [1:0] code, input logic [4:0] sub);
		unique case (code)
			2'b00: rate_hit = (sub % 5'(RATE_DIV_2)) == 5'h00;
			2'b01: rate_hit = (sub % 5'(RATE_DIV_5)) == 5'h00;
			2'b10: rate_hit = (sub % 5'(RATE_DIV_10)) == 5'h00;
			2'b11: rate_hit = 1'b1;
		endcase
	endfunction : rate_hit

	// tachometer period count in prescaled ticks
	logic [15:0] tach_cnt_r, tach_cnt_nxt, tach_val_r, tach_val_nxt;
	logic [10:0] tach_pre_r, tach_pre_nxt;
	logic tach_prev_r, slow_r;
	logic tach_tick;

	always_comb
	begin
		tach_tick = slow_r ? (tach_pre_r == 11'(TACH_TICK_CYC * SLOW_FACTOR - 1))
			: (tach_pre_r == 11'(TACH_TICK_CYC - 1));
		tach_pre_nxt = tach_tick ? 11'h000 : tach_pre_r + 11'h001;
		tach_cnt_nxt = tach_cnt_r;
		tach_val_nxt = tach_val_r;
		if (tach_tick && tach_cnt_r != CNT_MAX)
			tach_cnt_nxt = tach_cnt_r + 16'h0001;
		if (tach_one && !tach_prev_r)
		begin
			tach_val_nxt = tach_cnt_r;
			tach_cnt_nxt = '0;
		end
		else if (tach_cnt_r == CNT_MAX)
			tach_val_nxt = CNT_MAX;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tach_pre_r <= '0;
			tach_cnt_r <= '0;
			tach_val_r <= RST_CNT;
			tach_prev_r <= 1'b0;
		end
		else
		begin
			tach_pre_r <= tach_pre_nxt;
			tach_cnt_r <= tach_cnt_nxt;
			tach_val_r <= tach_val_nxt;
			tach_prev_r <= tach_one;
		end
	end

	// registers and bus
	logic [2:0] src_sel_r, src_sel_nxt;
	logic [3:0] mode_r, mode_nxt, up_rate_r, up_rate_nxt, down_rate_r, down_rate_nxt;
	logic [7:0] hys_r, hys_nxt, thr_r, thr_nxt, pon_r, pon_nxt;
	logic direct_r, direct_nxt, bank_r, bank_nxt, slow_nxt;
	logic [15:0] exp_r, exp_nxt, full_r, full_nxt, exp_auto;
	logic [7:0] cnt_lo_latch_r, cnt_lo_latch_nxt, full_lo_latch_r, full_lo_latch_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_take, rd_take;
	logic [7:0] widx, ridx, wbyte, segv [2];
	logic [23:0] full_scaled;
	fan_mode_t mode_one;

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = idx inside {IDX_SRC_MODE, IDX_HYS, IDX_RATE, IDX_START_STOP, IDX_PON,
			IDX_BANK, IDX_CNT_HI, IDX_CNT_LO, IDX_EXP_HI, IDX_EXP_LO, IDX_FULL_HI,
			IDX_FULL_LO};
	endfunction : is_mapped

	assign mode_one = fan_mode_t'(mode_r[1:0]);
	// write address and data are taken together; the master holds both meanwhile
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = !rvalid_r;
	assign wr_take = s_axi_awready;
	assign rd_take = s_axi_arvalid && !rvalid_r;
	assign widx = s_axi_awaddr[ADDR_W-1:IDX_LSB];
	assign ridx = s_axi_araddr[ADDR_W-1:IDX_LSB];
	assign wbyte = s_axi_wdata[7:0];
	// expected count grows with the fraction coded in the segment value
	assign full_scaled = 24'(full_r) * 24'(segv[0]);
	assign exp_auto = full_r + full_scaled[SEG_FRAC_SHIFT +: 16];

	always_comb
	begin
		src_sel_nxt = src_sel_r;
		mode_nxt = mode_r;
		hys_nxt = hys_r;
		up_rate_nxt = up_rate_r;
		down_rate_nxt = down_rate_r;
		direct_nxt = direct_r;
		thr_nxt = thr_r;
		pon_nxt = pon_r;
		bank_nxt = bank_r;
		slow_nxt = slow_r;
		exp_nxt = exp_r;
		full_nxt = full_r;
		cnt_lo_latch_nxt = cnt_lo_latch_r;
		full_lo_latch_nxt = full_lo_latch_r;
		bvalid_nxt = bvalid_r && !s_axi_bready;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r && !s_axi_rready;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (wr_take)
		begin
			bvalid_nxt = 1'b1;
			bresp_nxt = is_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_wstrb[0])
			begin
				unique case (widx)
					IDX_SRC_MODE:
						if (bank_r)
							src_sel_nxt = wbyte[2:0];
						else
							mode_nxt = wbyte[3:0];
					IDX_HYS: hys_nxt = wbyte;
					IDX_RATE:
						if (bank_r)
						begin
							direct_nxt = wbyte[DIRECT_BIT];
							down_rate_nxt = wbyte[3:0];
						end
						else
							up_rate_nxt = wbyte[3:0];
					IDX_START_STOP: thr_nxt = wbyte;
					IDX_PON: pon_nxt = wbyte;
					IDX_BANK:
					begin
						bank_nxt = wbyte[BANK_BIT];
						slow_nxt = wbyte[SLOW_BIT];
					end
					IDX_EXP_HI:
						if (mode_r[1])
							exp_nxt[15:8] = wbyte;
					IDX_EXP_LO:
						if (mode_r[1])
							exp_nxt[7:0] = wbyte;
					IDX_FULL_HI: full_nxt[15:8] = wbyte;
					IDX_FULL_LO: full_nxt[7:0] = wbyte;
					default: ;
				endcase
			end
		end
		// in automatic modes hardware owns the expected value
		if (mode_one == MODE_AUTO_RPM)
			exp_nxt = exp_auto;
		else if (mode_one == MODE_AUTO_DUTY)
			exp_nxt[7:0] = segv[0];
		if (rd_take)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
			rdata_nxt = '0;
			unique case (ridx)
				IDX_SRC_MODE: rdata_nxt[3:0] = bank_r ? {1'b0, src_sel_r} : mode_r;
				IDX_HYS: rdata_nxt[7:0] = hys_r;
				IDX_RATE: rdata_nxt[7:0] = bank_r ? {1'b0, direct_r, 2'b00, down_rate_r}
					: {4'h0, up_rate_r};
				IDX_START_STOP: rdata_nxt[7:0] = thr_r;
				IDX_PON: rdata_nxt[7:0] = pon_r;
				IDX_BANK: rdata_nxt[7:0] = {bank_r, slow_r, 6'h00};
				IDX_CNT_HI:
				begin
					rdata_nxt[7:0] = tach_val_r[15:8];
					cnt_lo_latch_nxt = tach_val_r[7:0];
				end
				IDX_CNT_LO: rdata_nxt[7:0] = cnt_lo_latch_r;
				IDX_EXP_HI: rdata_nxt[7:0] = exp_r[15:8];
				IDX_EXP_LO: rdata_nxt[7:0] = exp_r[7:0];
				IDX_FULL_HI:
				begin
					rdata_nxt[7:0] = full_r[15:8];
					full_lo_latch_nxt = full_r[7:0];
				end
				IDX_FULL_LO: rdata_nxt[7:0] = full_lo_latch_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_sel_r <= RST_SRC;
			mode_r <= RST_MODE;
			hys_r <= RST_HYS;
			up_rate_r <= RST_RATE;
			down_rate_r <= RST_RATE;
			direct_r <= 1'b0;
			thr_r <= RST_THR;
			pon_r <= RST_PON;
			bank_r <= 1'b0;
			slow_r <= 1'b0;
			exp_r <= RST_EXP;
			full_r <= RST_FULL;
			cnt_lo_latch_r <= RST_CNT[7:0];
			full_lo_latch_r <= RST_FULL[7:0];
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end
		else
		begin
			src_sel_r <= src_sel_nxt;
			mode_r <= mode_nxt;
			hys_r <= hys_nxt;
			up_rate_r <= up_rate_nxt;
			down_rate_r <= down_rate_nxt;
			direct_r <= direct_nxt;
			thr_r <= thr_nxt;
			pon_r <= pon_nxt;
			bank_r <= bank_nxt;
			slow_r <= slow_nxt;
			exp_r <= exp_nxt;
			full_r <= full_nxt;
			cnt_lo_latch_r <= cnt_lo_latch_nxt;
			full_lo_latch_r <= full_lo_latch_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// fan control
	logic [7:0] duty_r [2], duty_nxt [2], tgt [2], temp_sel [2];
	logic seg_hi_r [2], seg_hi_nxt [2], drive_r [2], drive_nxt [2];
	logic init_r, init_nxt;
	seg_cfg_t seg [2];

	assign seg[0] = seg_one;
	assign seg[1] = seg_two;

	always_comb
	begin
		temp_sel[1] = temp_fan_two;
		unique case (src_sel_t'(src_sel_r))
			SRC_EXT: temp_sel[0] = temps.ext;
			SRC_ONE: temp_sel[0] = temps.one;
			SRC_TWO_A, SRC_TWO_B: temp_sel[0] = temps.two;
			SRC_CPU: temp_sel[0] = temps.cpu;
			SRC_PCH: temp_sel[0] = temps.pch;
			SRC_MCH: temp_sel[0] = temps.mch;
			SRC_MAX: temp_sel[0] = temps.maxv;
		endcase
	end

	always_comb
	begin
		logic [8:0] t9, b9, low9;
		logic [3:0] hys, thr;
		logic [1:0] up, dn;
		t9 = '0;
		b9 = '0;
		low9 = '0;
		hys = '0;
		thr = '0;
		up = '0;
		dn = '0;
		init_nxt = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			hys = hys_r[4*i +: 4];
			thr = thr_r[4*i +: 4];
			up = up_rate_r[2*i +: 2];
			dn = down_rate_r[2*i +: 2];
			t9 = {temp_sel[i][7], temp_sel[i]};
			b9 = {seg[i].boundary[7], seg[i].boundary};
			low9 = b9 - {5'h00, hys};
			seg_hi_nxt[i] = seg_hi_r[i];
			if (!seg_hi_r[i] && $signed(t9) > $signed(b9))
				seg_hi_nxt[i] = 1'b1;
			else if (seg_hi_r[i] && $signed(t9) < $signed(low9))
				seg_hi_nxt[i] = 1'b0;
			segv[i] = seg_hi_r[i] ? seg[i].above : seg[i].below;
			tgt[i] = segv[i];
			// fan two has no expected-count registers, so it follows segment duty
			if (i == 0 && mode_r[0] == 1'b0)
				tgt[i] = (tach_val_r > exp_r) ? DUTY_FULL
					: (tach_val_r < exp_r) ? 8'h00 : duty_r[i];
			else if (i == 0 && mode_one == MODE_MAN_DUTY)
				tgt[i] = exp_r[7:0];
			duty_nxt[i] = duty_r[i];
			if (!init_r)
				duty_nxt[i] = pon_r;
			else if (direct_r)
				duty_nxt[i] = tgt[i];
			else if (tgt[i] > duty_r[i] && base_tick && rate_hit(up, sub_r))
				duty_nxt[i] = (duty_r[i] == 8'h00) ? 8'({thr, 3'b000})
					: duty_r[i] + 8'h01;
			else if (tgt[i] < duty_r[i] && base_tick && rate_hit(dn, sub_r))
				duty_nxt[i] = duty_r[i] - 8'h01;
			if (init_r && duty_nxt[i] < duty_r[i] && duty_nxt[i] < 8'({thr, 2'b00}))
				duty_nxt[i] = 8'h00;
			drive_nxt[i] = pwm_cnt_r < duty_r[i];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			init_r <= 1'b0;
			for (int i = 0; i < 2; i++)
			begin
				duty_r[i] <= '0;
				seg_hi_r[i] <= 1'b0;
				drive_r[i] <= 1'b0;
			end
		end
		else
		begin
			init_r <= init_nxt;
			for (int i = 0; i < 2; i++)
			begin
				duty_r[i] <= duty_nxt[i];
				seg_hi_r[i] <= seg_hi_nxt[i];
				drive_r[i] <= drive_nxt[i];
			end
		end
	end

	assign duty_one = duty_r[0];
	assign duty_two = duty_r[1];
	assign drive_output_one = drive_r[0];
	assign drive_output_two = drive_r[1];

	AST_PON_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
		!init_r |=> duty_r[0] == $past(pon_r) && duty_r[1] == $past(pon_r))
		else $error("duty not loaded from power-on value");
	AST_DIRECT: assert property (@(posedge aclk) disable iff (!aresetn)
		init_r && direct_r && tgt[0] >= 8'({thr_r[3:0], 2'b00}) |=> duty_r[0] == $past(tgt[0]))
		else $error("direct update did not reach target");
	AST_START_JUMP: assert property (@(posedge aclk) disable iff (!aresetn)
		init_r && !direct_r && duty_r[0] == 8'h00 ##1 duty_r[0] != 8'h00
		|-> duty_r[0] == 8'({$past(thr_r[3:0]), 3'b000}))
		else $error("start did not jump to threshold times eight");
	AST_STOP_FLOOR: assert property (@(posedge aclk) disable iff (!aresetn)
		init_r && $past(init_r) && duty_r[1] < $past(duty_r[1])
		|-> duty_r[1] == 8'h00 || duty_r[1] >= 8'({$past(thr_r[7:4]), 2'b00}))
		else $error("slowing duty left below stop threshold");
	AST_RAMP_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
		init_r && !direct_r && !base_tick |=> $stable(duty_r[0]))
		else $error("duty moved without a rate tick");
	AST_CNT_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_take && ridx == IDX_CNT_HI ##1 !rd_take
		##1 rd_take && ridx == IDX_CNT_LO ##1 1'b1
		|-> s_axi_rdata[7:0] == $past(tach_val_r[7:0], 3))
		else $error("count low byte not latched by high read");
	AST_BANK_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_take && widx == IDX_SRC_MODE && !bank_r |=> $stable(src_sel_r))
		else $error("source selector written with bank clear");
	AST_AUTO_RO: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_take && widx == IDX_EXP_LO && mode_one == MODE_AUTO_DUTY
		|=> exp_r[7:0] == $past(segv[0]))
		else $error("software wrote expected low in auto mode");
	AST_FULL_DUTY: assert property (@(posedge aclk) disable iff (!aresetn)
		duty_r[0] == DUTY_FULL [*2] |-> drive_r[0])
		else $error("full duty did not drive continuously");
	AST_SEG_UP: assert property (@(posedge aclk) disable iff (!aresetn)
		!seg_hi_r[0] && $signed({temp_sel[0][7], temp_sel[0]})
		> $signed({seg_one.boundary[7], seg_one.boundary}) |=> seg_hi_r[0])
		else $error("segment did not rise above boundary");
endmodule : fan_duty_control_config

// >>> tb/fan_duty_control_config_tb.sv
`timescale 1ns/1ps
module fan_duty_control_config_tb;
	import fan_cfg_pkg::*;
	// short base tick keeps ramp tests brief
	localparam int BT = 20;
	localparam int LIMIT = 60000;
	localparam logic [7:0] RI [11] = '{IDX_HYS, IDX_RATE, IDX_START_STOP, IDX_PON, IDX_BANK,
		IDX_SRC_MODE, IDX_CNT_HI, IDX_CNT_LO, IDX_FULL_HI, IDX_FULL_LO, IDX_EXP_HI};
	localparam logic [7:0] RV [11] = '{8'h44, 8'h05, 8'h55, 8'h66, 8'h00, 8'h05, 8'h0f, 8'hff,
		8'h03, 8'hff, 8'h00};
	localparam logic [7:0] HT [5] = '{8'h33, 8'h2e, 8'h2d, 8'h33, 8'h31};
	localparam logic [7:0] HE [5] = '{8'hc0, 8'hc0, 8'h40, 8'hc0, 8'h40};
	localparam int DIV [4] = '{10, 4, 2, 1};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tach_one, drv_one, drv_two;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] duty_one, duty_two;
	logic [7:0] temp_fan_two = 8'h00;
	temp_set_t temps = '0;
	seg_cfg_t seg_one = '{8'h00, 8'h66, 8'h66};
	seg_cfg_t seg_two = '{8'h00, 8'h66, 8'h66};
	logic [34:0] exq [$];
	logic [34:0] note;
	int num_errors = 0, compares = 0, cyc = 0, seed = 22;

	always #12.5 aclk = ~aclk;

	fan_duty_control_config #(.BASE_TICK_CYCLES(BT)) u_fan_duty_control_config (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.temps(temps), .temp_fan_two(temp_fan_two), .seg_one(seg_one), .seg_two(seg_two),
		.tach_one(tach_one), .drive_output_one(drv_one), .drive_output_two(drv_two),
		.duty_one(duty_one), .duty_two(duty_two));

	fan_model u_fan_model (.aclk(aclk), .drive_output_one(drv_one), .tach_one(tach_one));

	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		compares++;
		if (seen !== expv)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : chk

	task automatic wrap_up();
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rsp);
		logic aw_open, w_open;
		aw_open = 1'b1;
		w_open = 1'b1;
		exq.push_back({1'b0, rsp, 32'h0});
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// address and data may be taken at different edges
		while (aw_open || w_open)
		begin
			@(posedge aclk);
			if (aw_open && awready)
			begin
				awvalid <= 1'b0;
				aw_open = 1'b0;
			end
			if (w_open && wready)
			begin
				wvalid <= 1'b0;
				w_open = 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rsp);
		exq.push_back({1'b1, rsp, 24'h0, d});
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask : rd

	// which reading the fan one selector should pick
	function automatic logic [7:0] pick(input int c, input temp_set_t t);
		logic [7:0] v [8];
		v = '{t.ext, t.one, t.two, t.two, t.cpu, t.pch, t.mch, t.maxv};
		return v[c];
	endfunction : pick

	// fan one segment state for boundary 0 and hysteresis 4
	function automatic logic seg_step(input logic h, input logic [7:0] t);
		if (!h && $signed(t) > 0)
			return 1'b1;
		if (h && $signed(t) < -4)
			return 1'b0;
		return h;
	endfunction : seg_step

	// edges until duty_one next changes; bounded so a stuck ramp shows up
	task automatic nxt(output int n);
		logic [7:0] p;
		p = duty_one;
		n = 0;
		while (duty_one === p && n < 5000)
		begin
			@(posedge aclk);
			n++;
		end
	endtask : nxt

	task automatic ramp(input logic [7:0] tgt, input int gap, input int stp);
		logic [7:0] p;
		int n;
		wr(IDX_EXP_LO, tgt, RESP_OKAY);
		nxt(n);
		p = duty_one;
		nxt(n);
		chk(n, gap);
		chk(duty_one, 8'(p + stp));
	endtask : ramp

	// bus answers are compared in arrival order against the notes
	always @(posedge aclk)
		if ((bvalid && bready) || (rvalid && rready))
		begin
			note = exq.pop_front();
			if (note[34])
			begin
				chk({30'h0, rresp}, {30'h0, note[33:32]});
				chk(rdata, note[31:0]);
			end
			else
				chk({30'h0, bresp}, {30'h0, note[33:32]});
		end

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			num_errors++;
			wrap_up();
		end
	end

	initial
	begin
		logic [7:0] d;
		int hi;
		int hi2;
		int n;
		logic up1;
		temps = 56'({$random(seed), $random(seed)});
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		@(posedge aclk);
		#1;
		chk(duty_one, 8'h66);
		chk(duty_two, 8'h66);
		@(posedge aclk);
		wr(IDX_CNT_HI, 8'h12, RESP_OKAY);
		for (int i = 0; i < 11; i++)
			rd(RI[i], RV[i], RESP_OKAY);
		rd(8'h90, 8'h00, RESP_SLVERR);
		wr(8'h90, 8'h11, RESP_SLVERR);
		wr(IDX_EXP_LO, 8'h12, RESP_OKAY);
		rd(IDX_EXP_LO, 8'h66, RESP_OKAY);
		wr(IDX_BANK, 8'hc0, RESP_OKAY);
		rd(IDX_BANK, 8'hc0, RESP_OKAY);
		rd(IDX_SRC_MODE, 8'h00, RESP_OKAY);
		rd(IDX_RATE, 8'h05, RESP_OKAY);
		seg_one <= '{8'h00, 8'ha0, 8'h50};
		up1 = seg_step(1'b0, temps.ext);
		for (int c = 0; c < 8; c++)
		begin
			temps <= 56'({$random(seed), $random(seed)});
			wr(IDX_SRC_MODE, 8'(c), RESP_OKAY);
			// one segment step still sees the old source, the next the new one
			up1 = seg_step(seg_step(up1, pick((c == 0) ? 0 : c - 1, temps)), pick(c, temps));
			rd(IDX_SRC_MODE, 8'(c), RESP_OKAY);
			rd(IDX_EXP_LO, up1 ? 8'ha0 : 8'h50, RESP_OKAY);
		end
		wr(IDX_RATE, 8'h45, RESP_OKAY);
		wr(IDX_BANK, 8'h00, RESP_OKAY);
		rd(IDX_SRC_MODE, 8'h05, RESP_OKAY);
		wr(IDX_SRC_MODE, 8'h07, RESP_OKAY);
		for (int i = 0; i < 3; i++)
		begin
			d = (i == 0) ? 8'hff : 8'h20 + 8'($random(seed) & 32'h7f);
			wr(IDX_EXP_LO, d, RESP_OKAY);
			rd(IDX_EXP_LO, d, RESP_OKAY);
			repeat (8) @(posedge aclk);
			chk(duty_one, d);
			hi = 0;
			hi2 = 0;
			repeat (255 * PWM_STEP_CYC)
			begin
				@(posedge aclk);
				hi += drv_one;
				hi2 += drv_two;
			end
			chk(hi, 32'(d) * PWM_STEP_CYC);
			chk(hi2, 32'(8'h66) * PWM_STEP_CYC);
		end
		wr(IDX_BANK, 8'h80, RESP_OKAY);
		wr(IDX_RATE, 8'h05, RESP_OKAY);
		wr(IDX_BANK, 8'h00, RESP_OKAY);
		for (int c = 0; c < 4; c++)
		begin
			wr(IDX_RATE, 8'(4 + c), RESP_OKAY);
			ramp(8'hf0, BT * DIV[c], 1);
		end
		wr(IDX_BANK, 8'h80, RESP_OKAY);
		for (int c = 0; c < 4; c++)
		begin
			wr(IDX_RATE, 8'(4 + c), RESP_OKAY);
			ramp(8'h18, BT * DIV[c], -1);
		end
		wr(IDX_RATE, 8'h43, RESP_OKAY);
		wr(IDX_EXP_LO, 8'h15, RESP_OKAY);
		repeat (8) @(posedge aclk);
		chk(duty_one, 8'h15);
		wr(IDX_RATE, 8'h03, RESP_OKAY);
		wr(IDX_EXP_LO, 8'h08, RESP_OKAY);
		nxt(n);
		chk(duty_one, 8'h14);
		nxt(n);
		chk(duty_one, 8'h00);
		wr(IDX_BANK, 8'h00, RESP_OKAY);
		wr(IDX_RATE, 8'h07, RESP_OKAY);
		wr(IDX_EXP_LO, 8'h80, RESP_OKAY);
		nxt(n);
		chk(duty_one, 8'h28);
		nxt(n);
		chk(duty_one, 8'h29);
		wr(IDX_BANK, 8'h80, RESP_OKAY);
		wr(IDX_RATE, 8'h40, RESP_OKAY);
		seg_two <= '{8'h32, 8'hc0, 8'h40};
		for (int i = 0; i < 5; i++)
		begin
			if (i == 4)
				wr(IDX_HYS, 8'h04, RESP_OKAY);
			temp_fan_two <= HT[i];
			repeat (8) @(posedge aclk);
			chk(duty_two, HE[i]);
		end
		repeat (14000) @(posedge aclk);
		rd(IDX_CNT_HI, 8'h00, RESP_OKAY);
		repeat (4) @(posedge aclk);
		wrap_up();
	end
endmodule : fan_duty_control_config_tb

// >>> tb/fan_model.sv
`timescale 1ns/1ps
module fan_model #(
	parameter int HALF = 3000
) (
	// clock and drive
	input wire logic aclk,
	input wire logic drive_output_one,
	// tachometer
	output logic tach_one
);
	int idle_r = 0;
	int ph_r = 0;
	initial tach_one = 1'b0;
	// rotor coasts a while after drive stops, then the tach line stands low
	always @(posedge aclk)
	begin
		idle_r <= drive_output_one ? 0 : idle_r + 1;
		if (idle_r > 4 * HALF)
		begin
			tach_one <= 1'b0;
			ph_r <= 0;
		end
		else if (ph_r == HALF - 1)
		begin
			tach_one <= ~tach_one;
			ph_r <= 0;
		end
		else
			ph_r <= ph_r + 1;
	end
endmodule : fan_model
